// *** rtl/ptb_pkg.sv ***
// package: address map, fields, resets and shaper constants for ptb block
package ptb_pkg;
  localparam logic [16:0] RX_MEM_BASE = 17'h10000;
  localparam logic [16:0] RX_MEM_LAST = 17'h10FFC;
  localparam logic [16:0] TX_MEM_BASE = 17'h11000;
  localparam logic [16:0] TX_CTRL_OFS = 17'h12000;
  localparam logic [16:0] RX_CTRL_OFS = 17'h12004;
  localparam logic [16:0] DRAIN_OFS = 17'h1200C;
  localparam logic [16:0] FILL_OFS = 17'h12010;
  localparam int RX_BUFS = 16;
  localparam int TX_BUFS = 8;
  localparam int BUF_BYTES = 256;
  localparam int TX_FRAME_START = 7;
  localparam int TS_BYTE0 = 252;
  localparam int TX_SEND_LSB = 0;
  localparam int TX_WAIT_LSB = 8;
  localparam int TX_LAST_LSB = 16;
  localparam int RX_CLEAR_BIT = 0;
  localparam int RX_LAST_LSB = 8;
  localparam int RATE_W = 20;
  localparam logic [19:0] DRAIN_RST = 20'h00800;
  localparam logic [19:0] FILL_RST = 20'h01800;
  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESET_LEN = 8'h5A;
  localparam logic [7:0] PTP_ETYPE_HI = 8'h88;
  localparam logic [7:0] PTP_ETYPE_LO = 8'hF7;
  localparam int ETYPE_POS = 19;
  localparam int MSGTYPE_POS = 21;
  localparam int PRESET_BUFS = 7;
endpackage

// *** rtl/ptb_regs.sv ***
// ptp frame buffers, buffer control registers and credit shaper
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

module ptb_regs
  import ptb_pkg::*;
#(
  parameter bit AVB_PRESENT = 1'b1,
  parameter int CREDIT_W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [16:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // receive frame path
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_good,
  input wire logic [31:0] rx_stamp,
  input wire logic rx_read_done,
  // transmit frame path
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic [31:0] tx_stamp,
  // audio/video stream shaping
  input wire logic av_waiting,
  input wire logic av_sending,
  output logic av_grant,
  // interrupts
  output logic tx_done_irq,
  output logic rx_done_irq
);

  typedef enum logic [1:0] {PTB_IDLE, PTB_SEND, PTB_STAMP} ptb_tx_e;

  logic [7:0] rx_mem [RX_BUFS*BUF_BYTES];
  logic [7:0] tx_mem [TX_BUFS*BUF_BYTES];
  logic [3:0] rx_wr_ptr_r;
  logic [3:0] rx_rd_ptr_r;
  logic [3:0] rx_last_r;
  logic [7:0] rx_byte_r;
  logic [1:0] rx_ts_cnt_r;
  logic rx_ts_r;
  logic [7:0] tx_wait_r;
  logic [2:0] tx_last_idx_r;
  logic [2:0] tx_cur_r;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_len_r;
  logic [1:0] tx_ts_cnt_r;
  logic [31:0] tx_ts_hold_r;
  ptb_tx_e tx_state_r;
  logic [19:0] drain_rate_r;
  logic [19:0] fill_rate_r;
  logic signed [CREDIT_W-1:0] credit_r;
  logic [7:0] tx_send_req;
  logic tx_sel_valid;
  logic [2:0] tx_sel;
  logic init_done_r;
  logic [10:0] init_cnt_r;

  function automatic logic [7:0] preset_byte(input logic [10:0] a);
    logic [7:0] ofs;
    logic [2:0] b;
    ofs = a[7:0];
    b = a[10:8];
    preset_byte = 8'h00;
    if (b < 3'(PRESET_BUFS)) begin
      if (ofs == 8'h00) preset_byte = PRESET_LEN;
      else if (ofs == 8'(ETYPE_POS)) preset_byte = PTP_ETYPE_HI;
      else if (ofs == 8'(ETYPE_POS + 1)) preset_byte = PTP_ETYPE_LO;
      else if (ofs == 8'(MSGTYPE_POS)) preset_byte = {5'h00, b};
    end
  endfunction

  function automatic logic [7:0] stamp_byte(input logic [31:0] ts,
                                            input logic [1:0] i);
    stamp_byte = ts[8*i +: 8];
  endfunction

  wire in_rx = AVB_PRESENT && reg_addr >= RX_MEM_BASE &&
               reg_addr[16:2] <= RX_MEM_LAST[16:2];
  wire in_tx = AVB_PRESENT && reg_addr >= TX_MEM_BASE &&
               reg_addr < TX_CTRL_OFS;
  wire tx_ctrl_hit = AVB_PRESENT && reg_addr == TX_CTRL_OFS;
  wire rx_ctrl_hit = AVB_PRESENT && reg_addr == RX_CTRL_OFS;

  assign tx_send_req = (reg_wr && tx_ctrl_hit) ?
                       reg_wdata[TX_SEND_LSB +: 8] : 8'h00;

  always_comb begin
    tx_sel_valid = 1'b0;
    tx_sel = 3'h0;
    for (int i = TX_BUFS - 1; i >= 0; i--) begin
      if (tx_wait_r[i]) begin
        tx_sel_valid = 1'b1;
        tx_sel = 3'(i);
      end
    end
  end

  // register read port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (in_rx) begin
          reg_rdata <= {24'h000000, rx_mem[reg_addr[11:0]]};
        end else if (in_tx) begin
          reg_rdata <= {24'h000000, tx_mem[reg_addr[10:0]]};
        end else if (tx_ctrl_hit) begin
          reg_rdata <= {13'h0000, tx_last_idx_r, tx_wait_r,
                        8'h00};
        end else if (rx_ctrl_hit) begin
          reg_rdata <= {20'h00000, rx_last_r, 8'h00};
        end else if (AVB_PRESENT && reg_addr == DRAIN_OFS) begin
          reg_rdata <= {12'h000, drain_rate_r};
        end else if (AVB_PRESENT && reg_addr == FILL_OFS) begin
          reg_rdata <= {12'h000, fill_rate_r};
        end
      end
    end
  end

  // shaper rate registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drain_rate_r <= DRAIN_RST;
      fill_rate_r <= FILL_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == DRAIN_OFS) drain_rate_r <= reg_wdata[19:0];
      if (reg_addr == FILL_OFS) fill_rate_r <= reg_wdata[19:0];
    end
  end

  // credit shaper
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      credit_r <= '0;
      av_grant <= 1'b0;
    end else if (clk_en) begin
      if (av_sending) begin
        credit_r <= credit_r - CREDIT_W'(drain_rate_r);
      end else if (av_waiting || credit_r < 0) begin
        credit_r <= credit_r + CREDIT_W'(fill_rate_r);
      end else begin
        credit_r <= '0;
      end
      av_grant <= av_waiting && credit_r >= 0;
    end
  end

  // receive memory write and ring
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (rx_valid && rx_byte_r < 8'(TS_BYTE0)) begin
        rx_mem[{rx_wr_ptr_r, rx_byte_r}] <= rx_data;
      end
      if (rx_ts_r) begin
        rx_mem[{rx_last_r, 8'(TS_BYTE0) + 8'(rx_ts_cnt_r)}] <=
          stamp_byte(rx_stamp, rx_ts_cnt_r);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_wr_ptr_r <= 4'h0;
      rx_rd_ptr_r <= 4'h0;
      rx_last_r <= 4'h0;
      rx_byte_r <= 8'h00;
      rx_ts_r <= 1'b0;
      rx_ts_cnt_r <= 2'h0;
      rx_done_irq <= 1'b0;
    end else if (clk_en) begin
      if (rx_read_done) rx_rd_ptr_r <= rx_rd_ptr_r + 4'h1;
      if (rx_ts_r) begin
        rx_ts_cnt_r <= rx_ts_cnt_r + 2'h1;
        if (rx_ts_cnt_r == 2'h3) rx_ts_r <= 1'b0;
      end
      if (rx_valid) begin
        if (rx_last) begin
          rx_byte_r <= 8'h00;
          if (rx_good && !rx_ts_r) begin
            rx_last_r <= rx_wr_ptr_r;
            rx_wr_ptr_r <= rx_wr_ptr_r + 4'h1;
            rx_ts_r <= 1'b1;
            rx_ts_cnt_r <= 2'h0;
          end
        end else if (rx_byte_r != 8'(TS_BYTE0)) begin
          rx_byte_r <= rx_byte_r + 8'h01;
        end
      end
      if (reg_wr && rx_ctrl_hit && reg_wdata[RX_CLEAR_BIT]) begin
        rx_wr_ptr_r <= rx_rd_ptr_r;
      end
      if (rx_ts_r && rx_ts_cnt_r == 2'h3) begin
        rx_done_irq <= 1'b1;
      end else if ((reg_wr || reg_rd) && rx_ctrl_hit) begin
        rx_done_irq <= 1'b0;
      end
    end
  end

  // transmit memory, preset and cpu writes
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (!init_done_r) begin
        tx_mem[init_cnt_r] <= preset_byte(init_cnt_r);
      end else if (tx_state_r == PTB_STAMP) begin
        tx_mem[{tx_cur_r, 8'(TS_BYTE0) + 8'(tx_ts_cnt_r)}] <=
          stamp_byte(tx_ts_hold_r, tx_ts_cnt_r);
      end else if (reg_wr && in_tx) begin
        tx_mem[reg_addr[10:0]] <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
      init_cnt_r <= 11'h000;
    end else if (clk_en && !init_done_r) begin
      init_cnt_r <= init_cnt_r + 11'h001;
      if (init_cnt_r == 11'h7FF) init_done_r <= 1'b1;
    end
  end

  // transmit engine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= PTB_IDLE;
      tx_wait_r <= TX_CTRL_RST;
      tx_cur_r <= 3'h0;
      tx_cnt_r <= 8'h00;
      tx_len_r <= 8'h00;
      tx_last_idx_r <= 3'h0;
      tx_ts_cnt_r <= 2'h0;
      tx_ts_hold_r <= 32'h0000_0000;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      tx_done_irq <= 1'b0;
    end else if (clk_en) begin
      tx_wait_r <= tx_wait_r | tx_send_req;
      unique case (tx_state_r)
        PTB_IDLE: begin
          if (tx_sel_valid && init_done_r) begin
            tx_cur_r <= tx_sel;
            tx_len_r <= tx_mem[{tx_sel, 8'h00}];
            tx_cnt_r <= 8'h00;
            tx_valid <= 1'b0;
            tx_state_r <= PTB_SEND;
          end
        end
        PTB_SEND: begin
          if (tx_len_r == 8'h00) begin
            tx_wait_r[tx_cur_r] <= tx_send_req[tx_cur_r];
            tx_state_r <= PTB_IDLE;
          end else if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              tx_ts_hold_r <= tx_stamp;
              tx_ts_cnt_r <= 2'h0;
              tx_state_r <= PTB_STAMP;
            end else begin
              tx_valid <= 1'b1;
              tx_data <= tx_mem[{tx_cur_r,
                                 8'(TX_FRAME_START) + tx_cnt_r}];
              tx_last <= tx_cnt_r == tx_len_r - 8'h01;
              tx_cnt_r <= tx_cnt_r + 8'h01;
            end
          end
        end
        PTB_STAMP: begin
          tx_ts_cnt_r <= tx_ts_cnt_r + 2'h1;
          if (tx_ts_cnt_r == 2'h3) begin
            tx_wait_r[tx_cur_r] <= tx_send_req[tx_cur_r];
            tx_last_idx_r <= tx_cur_r;
            tx_state_r <= PTB_IDLE;
          end
        end
      endcase
      if (tx_state_r == PTB_STAMP && tx_ts_cnt_r == 2'h3) begin
        tx_done_irq <= 1'b1;
      end else if ((reg_wr || reg_rd) && tx_ctrl_hit) begin
        tx_done_irq <= 1'b0;
      end
    end
  end

  // checks
  sequence rx_frame_end_s;
    clk_en && rx_valid && rx_last && rx_good && !rx_ts_r;
  endsequence

  rx_ptr_adv_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_frame_end_s and !(reg_wr && rx_ctrl_hit)) |=>
    rx_wr_ptr_r == $past(rx_wr_ptr_r) + 4'h1)
    else $error("rx write pointer did not advance");
  rx_irq_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_end_s ##1 (clk_en [*4]) |=> rx_done_irq)
    else $error("rx done interrupt missing");
  rx_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && rx_ctrl_hit && reg_wdata[0] |=>
    rx_wr_ptr_r == $past(rx_rd_ptr_r))
    else $error("rx clear failed");
  tx_irq_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && tx_ctrl_hit && tx_state_r != PTB_STAMP
    |=> !tx_done_irq)
    else $error("tx done interrupt not cleared");
  tx_pend_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && |tx_send_req |=>
    (tx_wait_r & $past(tx_send_req)) == $past(tx_send_req))
    else $error("pending flag not set");
  tx_send_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && $past(reg_rd && tx_ctrl_hit) |-> reg_rdata[7:0] == 8'h00)
    else $error("send bits read nonzero");
  rate_reset_a: assert property (@(posedge clock)
    !rst_n |=> drain_rate_r == DRAIN_RST && fill_rate_r == FILL_RST)
    else $error("rate reset values wrong");
  av_credit_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && av_waiting && credit_r < 0 |=> !av_grant)
    else $error("av grant with negative credit");
  tx_done_last_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(tx_done_irq) |-> tx_last_idx_r == tx_cur_r)
    else $error("last tx index wrong");

endmodule

// *** test/ptb_mac.sv ***
// mac-side partner: stalling transmit sink and receive frame source
`timescale 1ns/1ps
module ptb_mac (
  // clock
  input wire logic clock,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [31:0] tx_stamp,
  // receive stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_good,
  output logic [31:0] rx_stamp
);
  logic [7:0] txq[$];
  logic [31:0] last_stamp;
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    tx_ready = 1'b0;
    tx_stamp = 32'h0;
    last_stamp = 32'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_good = 1'b1;
    rx_stamp = 32'h0;
  end
  // every fourth cycle stalls
  always @(posedge clock) begin
    cnt <= cnt + 2'h1;
    tx_ready <= cnt != 2'h3;
    tx_stamp <= tx_stamp + 32'h1;
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_data);
      if (tx_last)
        last_stamp <= tx_stamp;
    end
  end
  // byte i of a frame is st[7:0]+i
  task send_rx(input int n, input logic [31:0] st, input logic good);
    rx_stamp <= st;
    rx_good <= good;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= st[7:0] + 8'(i);
      rx_last <= i == n - 1;
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
    repeat (6) @(posedge clock);
    rx_stamp <= ~st;
  endtask
endmodule

// *** test/ptb_regs_bench.sv ***
// self-checking bench for the ptp buffer and shaper registers
`timescale 1ns/1ps
module ptb_regs_bench;
  import ptb_pkg::*;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic rx_read_done = 0, av_waiting = 0, av_sending = 0, clk_en = 1;
  logic [16:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, tx_stamp, rx_stamp, e, m, v;
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_good;
  logic [7:0] tx_data, rx_data, pay[5];
  logic av_grant, tx_done_irq, rx_done_irq;
  logic [31:0] expq[$], mskq[$];
  int miscompares = 0, n_checks = 0, cycles = 0, seed = 16566, i;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  always #12.5 clock = ~clock;
  ptb_regs uut (.clock, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data, .rx_last, .rx_good,
    .rx_stamp, .rx_read_done, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .tx_stamp, .av_waiting, .av_sending, .av_grant, .tx_done_irq,
    .rx_done_irq);
  ptb_mac mac (.clock, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .tx_stamp, .rx_valid, .rx_data, .rx_last, .rx_good, .rx_stamp);
  function automatic logic [16:0] ba(input logic [16:0] b, input int n,
    input int o);
    return b + 17'(n * 256 + o);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task final_report;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [16:0] a, input logic [31:0] x, input logic [31:0] k);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(x);
    mskq.push_back(k);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task rstamp(input logic [16:0] a, input logic [31:0] s);
    for (int j = 0; j < 4; j++)
      rd(a + 17'(j), {24'h0, s[8*j+:8]}, 32'hFF);
  endtask
  task wait_irq(input bit rx, input logic x);
    for (int j = 0; j < 400; j++) begin
      @(negedge clock);
      if ((rx ? rx_done_irq : tx_done_irq) === x)
        break;
    end
    chk({31'h0, rx ? rx_done_irq : tx_done_irq}, {31'h0, x});
  endtask
  task pulse_done;
    @(posedge clock);
    rx_read_done <= 1'b1;
    @(posedge clock);
    rx_read_done <= 1'b0;
  endtask
  // read data checker: oldest note against the answer
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      e = expq.pop_front();
      m = mskq.pop_front();
      chk(reg_rdata & m, e & m);
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(DRAIN_OFS, 32'h800, ALL);
    rd(FILL_OFS, 32'h1800, ALL);
    rd(TX_CTRL_OFS, 32'h0, ALL);
    rd(RX_CTRL_OFS, 32'h0, ALL);
    rd(17'h12008, 32'h0, ALL);
    v = $random(seed);
    wr(DRAIN_OFS, v);
    rd(DRAIN_OFS, v & 32'hFFFFF, ALL);
    wr(FILL_OFS, ~v);
    rd(FILL_OFS, ~v & 32'hFFFFF, ALL);
    repeat (2100) @(posedge clock);
    for (i = 0; i < 7; i++) begin
      rd(ba(TX_MEM_BASE, i, 0), 32'(PRESET_LEN), 32'hFF);
      rd(ba(TX_MEM_BASE, i, 19), 32'h88, 32'hFF);
      rd(ba(TX_MEM_BASE, i, 20), 32'hF7, 32'hFF);
      rd(ba(TX_MEM_BASE, i, 21), 32'(i), 32'hFF);
    end
    rd(ba(TX_MEM_BASE, 7, 19), 32'h0, 32'hFF);
    // five random bytes from buffer 7
    wr(ba(TX_MEM_BASE, 7, 0), 32'h5);
    for (i = 0; i < 5; i++) begin
      pay[i] = 8'($random(seed));
      wr(ba(TX_MEM_BASE, 7, 7 + i), {24'h0, pay[i]});
    end
    wr(TX_CTRL_OFS, 32'h80);
    rd(TX_CTRL_OFS, 32'h8000, 32'h80FF);
    wait_irq(1'b0, 1'b1);
    chk(32'(mac.txq.size()), 32'h5);
    for (i = 0; i < 5; i++)
      chk({24'h0, mac.txq[i]}, {24'h0, pay[i]});
    rd(TX_CTRL_OFS, 32'h70000, 32'h7FFFF);
    wait_irq(1'b0, 1'b0);
    rstamp(ba(TX_MEM_BASE, 7, 252), mac.last_stamp);
    // first frame, then a clear, then seventeen frames around the ring
    v = $random(seed);
    mac.send_rx(10, v, 1'b1);
    wait_irq(1'b1, 1'b1);
    rd(RX_CTRL_OFS, 32'h0, 32'hF01);
    wait_irq(1'b1, 1'b0);
    for (i = 0; i < 10; i++)
      rd(ba(RX_MEM_BASE, 0, i), {24'h0, v[7:0] + 8'(i)}, 32'hFF);
    rstamp(ba(RX_MEM_BASE, 0, 252), v);
    // a bad frame neither moves the ring nor raises the interrupt
    mac.send_rx(3, ~v, 1'b0);
    chk({31'h0, rx_done_irq}, 32'h0);
    rd(RX_CTRL_OFS, 32'h0, 32'hF01);
    wr(RX_CTRL_OFS, 32'h1);
    for (i = 0; i <= 16; i++) begin
      v = $random(seed);
      mac.send_rx(2, v, 1'b1);
      wait_irq(1'b1, 1'b1);
      rd(RX_CTRL_OFS, {20'h0, 4'(i), 8'h0}, ALL);
      rd(ba(RX_MEM_BASE, i % 16, 1), {24'h0, v[7:0] + 8'h1}, 32'hFF);
      if (i == 15)
        rstamp(17'h10FFC, v);
      pulse_done();
    end
    // shaper: grant, overspend, recover, withdraw
    wr(DRAIN_OFS, 32'd100);
    wr(FILL_OFS, 32'd30);
    av_waiting <= 1'b1;
    repeat (3) @(negedge clock);
    chk({31'h0, av_grant}, 32'h1);
    @(posedge clock);
    av_sending <= 1'b1;
    repeat (3) @(posedge clock);
    av_sending <= 1'b0;
    repeat (2) @(negedge clock);
    chk({31'h0, av_grant}, 32'h0);
    repeat (15) @(negedge clock);
    chk({31'h0, av_grant}, 32'h1);
    @(posedge clock);
    av_waiting <= 1'b0;
    repeat (3) @(negedge clock);
    chk({31'h0, av_grant}, 32'h0);
    // clock enable low: a write must not land
    clk_en <= 1'b0;
    wr(DRAIN_OFS, 32'h5);
    clk_en <= 1'b1;
    rd(DRAIN_OFS, 32'd100, ALL);
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule
